// ==== acc_defs.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_OFF_CTRL0_B1 4'h0
`define ACC_OFF_CTRL0_B14 4'h1
`define ACC_OFF_RES0L_B1 4'h2
`define ACC_OFF_RES0H_B1 4'h3
`define ACC_OFF_RES0L_B14 4'h4
`define ACC_OFF_RES0H_B14 4'h5
`define ACC_OFF_COMMON 4'h6
`define ACC_OFF_STATE 4'h7
`define ACC_OFF_PERIPH_IRQ_ENABLE_1 4'h8
`define ACC_OFF_PERIPH_IRQ_FLAG_1 4'h9
`define ACC_OFF_INTCTL 4'hA
`define ACC_OFF_IRQ_STAT 4'hB
`define ACC_OFF_IRQ_MASK 4'hC
`define ACC_BIT_ON 0
`define ACC_BIT_GO 1
`define ACC_SEL_LSB 2
`define ACC_SEL_MSB 6
`define ACC_BIT_IE 6
`define ACC_BIT_PERIPHERAL_IRQ_GATE 6
`define ACC_BIT_DSEN 0
`define ACC_CS_LSB 4
`define ACC_CS_MSB 6
`define ACC_CS_RC 3'h7
`define ACC_RST_CTRL0 8'h00
`define ACC_RST_PERIPH_IRQ_ENABLE_1 8'h00
`define ACC_RST_COMMON 8'h00
`define ACC_IRQ_DONE 0
`define ACC_IRQ_ABORT 1
`define ACC_INSTR_DIV 4
`endif

// ==== acc_pkg.sv ====
// types shared by the conversion control files
package acc_pkg;
    typedef enum logic [3:0] {
        ACC_IDLE = 4'b0001,
        ACC_WAIT = 4'b0010,
        ACC_CONV = 4'b0100,
        ACC_DONE = 4'b1000
    } acc_state_e;
    typedef logic [4:0] acc_sel_t;
endpackage

// ==== acc_route.sv ====
// input select decoder for the analog multiplexer
`timescale 1ns/10ps
`include "acc_defs.svh"
module acc_route
    import acc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire acc_sel_t sel,
    output logic [16:0] ext_route,
    output logic vref_route,
    output logic temp_route,
    output logic fvr_route,
    output logic reserved_sel
);
    function automatic logic is_ext(input acc_sel_t s);
        is_ext = (s == 5'h00) || (s == 5'h01) || (s == 5'h02) ||
            ((s >= 5'h0A) && (s <= 5'h10));
    endfunction
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_route <= 17'h00000;
            vref_route <= 1'b0;
            temp_route <= 1'b0;
            fvr_route <= 1'b0;
            reserved_sel <= 1'b0;
        end else begin
            // disabled converter disconnects every input
            ext_route <= (enable && is_ext(sel)) ? (17'h00001 << sel) : 17'h00000;
            vref_route <= enable && (sel == 5'h1B);
            temp_route <= enable && (sel == 5'h1D);
            fvr_route <= enable && (sel == 5'h1F);
            reserved_sel <= !(is_ext(sel) || sel == 5'h1B || sel == 5'h1D || sel == 5'h1F);
        end
    end
endmodule

// ==== acc_seq.sv ====
// conversion sequencer: start delay, single or double sample, stop
`timescale 1ns/10ps
`include "acc_defs.svh"
module acc_seq
    import acc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_tick,
    input wire logic enable,
    input wire logic go_set,
    input wire logic go_clear,
    input wire logic rc_clock,
    input wire logic double_sample,
    input wire logic core_done,
    output logic core_start,
    output logic core_stop,
    output logic busy,
    output logic finished,
    output logic aborted,
    output logic second
);
    acc_state_e state_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ACC_IDLE;
            core_start <= 1'b0;
            core_stop <= 1'b0;
            finished <= 1'b0;
            aborted <= 1'b0;
            second <= 1'b0;
        end else begin
            core_start <= 1'b0;
            core_stop <= 1'b0;
            finished <= 1'b0;
            aborted <= 1'b0;
            unique case (state_reg)
                ACC_IDLE: begin
                    second <= 1'b0;
                    if (go_set && enable) begin
                        if (rc_clock) begin
                            state_reg <= ACC_WAIT;
                        end else begin
                            state_reg <= ACC_CONV;
                            core_start <= 1'b1;
                        end
                    end
                end
                ACC_WAIT: begin
                    if (!enable || go_clear) begin
                        state_reg <= ACC_IDLE;
                    end else if (instr_tick) begin
                        state_reg <= ACC_CONV;
                        core_start <= 1'b1;
                    end
                end
                ACC_CONV: begin
                    if (!enable || go_clear) begin
                        state_reg <= ACC_IDLE;
                        core_stop <= 1'b1;
                        aborted <= 1'b1;
                    end else if (core_done) begin
                        if (double_sample && !second) begin
                            second <= 1'b1;
                            core_start <= 1'b1;
                        end else begin
                            state_reg <= ACC_DONE;
                        end
                    end
                end
                ACC_DONE: begin
                    state_reg <= ACC_IDLE;
                    finished <= 1'b1;
                end
                default: state_reg <= ACC_IDLE;
            endcase
        end
    end
    assign busy = (state_reg != ACC_IDLE);
endmodule

// ==== acc_top.sv ====
// conversion control block with Avalon-MM register slave
// Operation
// - bit 7 of control reads zero
// - five-bit select routes inputs 0-2,10-16
// - special codes route reference, temperature, buffer
// - set go with converter on starts conversion
// - RC clock delays start one instruction
// - go flag clears itself at completion
// - clearing go stops, keeps partial, no flag
// - off bit disconnects inputs, go reads zero
// - double sample clears go after second
// - control register seen at two locations
// - interrupt enable bit gates converter interrupt
// - both bank locations are one register
`timescale 1ns/10ps
`include "acc_defs.svh"
module acc_top
    import acc_pkg::*;
#(
    parameter int INSTR_DIV = `ACC_INSTR_DIV
)(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [1:0] AVS_RESPONSE,
    input wire logic CORE_DONE,
    input wire logic [9:0] CORE_RESULT,
    output logic CORE_START,
    output logic CORE_STOP,
    output logic CORE_POWER,
    output logic [16:0] ROUTE_EXT,
    output logic ROUTE_VREF,
    output logic ROUTE_TEMP,
    output logic ROUTE_FVR,
    output logic CONV_IRQ,
    output logic IRQ
);
    logic [4:0] input_select_reg;
    logic converter_on_reg;
    logic convert_go_flag;
    logic [7:0] common_reg;
    logic [7:0] periph_irq_enable_1_reg;
    logic conv_irq_flag_reg;
    logic [7:0] intctl_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [9:0] result_reg;
    logic [7:0] div_reg;
    logic instr_tick;
    logic ack_reg;
    logic [31:0] rdata_next;
    logic hit;
    logic wr_go;
    logic go_set;
    logic go_clear;
    logic busy;
    logic finished;
    logic aborted;
    logic second;
    logic seq_start;
    logic seq_stop;
    logic reserved_sel;
    logic ctrl_sel;
    logic [7:0] ctrl_view;
    // reset image of control register 0
    localparam logic [7:0] CTRL0_RST = `ACC_RST_CTRL0;

    function automatic logic is_ctrl(input logic [3:0] a);
        is_ctrl = (a == `ACC_OFF_CTRL0_B1) || (a == `ACC_OFF_CTRL0_B14);
    endfunction

    // write strobe for one register location
    function automatic logic wr_at(input logic strobe, input logic [3:0] adr,
        input logic [3:0] loc);
        wr_at = strobe && (adr == loc);
    endfunction

    // a write lands at the edge that ends the cycle with waitrequest low
    assign wr_go = AVS_WRITE && ack_reg && AVS_BYTEENABLE[0];
    assign ctrl_sel = wr_go && is_ctrl(AVS_ADDRESS);
    // setting go while busy is ignored, a zero always stops
    assign go_set = ctrl_sel && AVS_WRITEDATA[`ACC_BIT_GO] && !busy;
    assign go_clear = ctrl_sel && !AVS_WRITEDATA[`ACC_BIT_GO];
    // go flag is the sequencer state, forced low when off
    assign convert_go_flag = busy && converter_on_reg;
    assign ctrl_view = {1'b0, input_select_reg, convert_go_flag, converter_on_reg};

    // instruction cycle tick
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            div_reg <= 8'h00;
        end else if (div_reg == 8'(INSTR_DIV - 1)) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign instr_tick = (div_reg == 8'(INSTR_DIV - 1));

    // one wait state per access: waitrequest drops in the cycle after a request is seen
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ack_reg <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_reg);
        end
    end

    // read data and response stand while waitrequest is low
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            AVS_READDATA <= 32'h00000000;
            AVS_RESPONSE <= 2'h0;
        end else begin
            AVS_READDATA <= rdata_next;
            AVS_RESPONSE <= hit ? 2'h0 : 2'h2;
        end
    end

    always_comb begin
        rdata_next = 32'h00000000;
        hit = 1'b1;
        unique case (AVS_ADDRESS)
            `ACC_OFF_CTRL0_B1, `ACC_OFF_CTRL0_B14: rdata_next = {24'h000000, ctrl_view};
            `ACC_OFF_RES0L_B1, `ACC_OFF_RES0L_B14: rdata_next = {24'h000000, result_reg[7:0]};
            `ACC_OFF_RES0H_B1, `ACC_OFF_RES0H_B14: rdata_next = {30'h00000000, result_reg[9:8]};
            `ACC_OFF_COMMON: rdata_next = {24'h000000, common_reg};
            `ACC_OFF_STATE: rdata_next = {29'h00000000, busy, second, reserved_sel};
            `ACC_OFF_PERIPH_IRQ_ENABLE_1: rdata_next = {24'h000000, periph_irq_enable_1_reg};
            `ACC_OFF_PERIPH_IRQ_FLAG_1: rdata_next = {25'h0000000, conv_irq_flag_reg, 6'h00};
            `ACC_OFF_INTCTL: rdata_next = {24'h000000, intctl_reg};
            `ACC_OFF_IRQ_STAT: rdata_next = {30'h00000000, irq_stat_reg};
            `ACC_OFF_IRQ_MASK: rdata_next = {30'h00000000, irq_mask_reg};
            default: hit = 1'b0;
        endcase
    end

    // control register 0, one copy behind both locations
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            input_select_reg <= CTRL0_RST[`ACC_SEL_MSB:`ACC_SEL_LSB];
        end else if (ctrl_sel) begin
            input_select_reg <= AVS_WRITEDATA[`ACC_SEL_MSB:`ACC_SEL_LSB];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            converter_on_reg <= CTRL0_RST[`ACC_BIT_ON];
        end else if (ctrl_sel) begin
            converter_on_reg <= AVS_WRITEDATA[`ACC_BIT_ON];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            common_reg <= `ACC_RST_COMMON;
        end else if (wr_at(wr_go, AVS_ADDRESS, `ACC_OFF_COMMON)) begin
            common_reg <= AVS_WRITEDATA[7:0];
        end
    end

    // bit 2 of the enable register is not implemented and reads zero
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            periph_irq_enable_1_reg <= `ACC_RST_PERIPH_IRQ_ENABLE_1;
        end else if (wr_at(wr_go, AVS_ADDRESS, `ACC_OFF_PERIPH_IRQ_ENABLE_1)) begin
            periph_irq_enable_1_reg <= AVS_WRITEDATA[7:0] & 8'hFB;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            intctl_reg <= 8'h00;
        end else if (wr_at(wr_go, AVS_ADDRESS, `ACC_OFF_INTCTL)) begin
            intctl_reg <= AVS_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_mask_reg <= 2'h0;
        end else if (wr_at(wr_go, AVS_ADDRESS, `ACC_OFF_IRQ_MASK)) begin
            irq_mask_reg <= AVS_WRITEDATA[1:0];
        end
    end

    // converter interrupt flag: hardware set wins over software write
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            conv_irq_flag_reg <= 1'b0;
        end else if (finished) begin
            conv_irq_flag_reg <= 1'b1;
        end else if (wr_go && AVS_ADDRESS == `ACC_OFF_PERIPH_IRQ_FLAG_1) begin
            conv_irq_flag_reg <= AVS_WRITEDATA[`ACC_BIT_IE];
        end
    end

    // sticky event status, write one to clear, set wins
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_stat_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == `ACC_IRQ_DONE && finished) || (i == `ACC_IRQ_ABORT && aborted)) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (wr_go && AVS_ADDRESS == `ACC_OFF_IRQ_STAT && AVS_WRITEDATA[i]) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
        end
    end

    // result capture, partial on stop as well
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            result_reg <= 10'h000;
        end else if ((busy && CORE_DONE) || aborted) begin
            result_reg <= CORE_RESULT;
        end
    end

    // delivery needs the gate software sets in interrupt control
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CONV_IRQ <= 1'b0;
        end else begin
            CONV_IRQ <= conv_irq_flag_reg && periph_irq_enable_1_reg[`ACC_BIT_IE] &&
                intctl_reg[`ACC_BIT_PERIPHERAL_IRQ_GATE];
        end
    end

    // one level line for all unmasked events
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // converter power follows the on bit
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CORE_POWER <= 1'b0;
        end else begin
            CORE_POWER <= converter_on_reg;
        end
    end

    // a start is dropped in the cycle the converter is switched off
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CORE_START <= 1'b0;
            CORE_STOP <= 1'b0;
        end else begin
            CORE_START <= seq_start && converter_on_reg;
            CORE_STOP <= seq_stop;
        end
    end

    // start, stop and completion sequencing
    acc_seq u_seq (
        .clk(CLK_SYS),
        .rst(RST),
        .instr_tick(instr_tick),
        .enable(converter_on_reg),
        .go_set(go_set && converter_on_reg),
        .go_clear(go_clear),
        .rc_clock(common_reg[`ACC_CS_MSB:`ACC_CS_LSB] == `ACC_CS_RC),
        .double_sample(common_reg[`ACC_BIT_DSEN]),
        .core_done(CORE_DONE),
        .core_start(seq_start),
        .core_stop(seq_stop),
        .busy(busy),
        .finished(finished),
        .aborted(aborted),
        .second(second)
    );

    // input routing follows the select field
    acc_route u_route (
        .clk(CLK_SYS),
        .rst(RST),
        .enable(converter_on_reg),
        .sel(input_select_reg),
        .ext_route(ROUTE_EXT),
        .vref_route(ROUTE_VREF),
        .temp_route(ROUTE_TEMP),
        .fvr_route(ROUTE_FVR),
        .reserved_sel(reserved_sel)
    );
endmodule

// ==== acc_top_assertions.sv ====
// concurrent checks on the conversion control ports
`timescale 1ns/10ps
module acc_top_assertions (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [1:0] AVS_RESPONSE,
    input wire logic CORE_START,
    input wire logic CORE_STOP,
    input wire logic CORE_POWER,
    input wire logic [16:0] ROUTE_EXT,
    input wire logic ROUTE_VREF,
    input wire logic ROUTE_TEMP,
    input wire logic ROUTE_FVR
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_req;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence s_ans;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    a_ans_one: assert property (s_req |=> s_ans)
        else $error("answer not one cycle after request");
    a_bit7_zero: assert property (
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS <= 4'h1 |-> !AVS_READDATA[7])
        else $error("control bit 7 read as one");
    a_unmapped_resp: assert property ((AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST
        && AVS_ADDRESS > 4'hC |-> AVS_RESPONSE == 2'h2 && (AVS_WRITE || AVS_READDATA == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_ok: assert property ((AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST
        && AVS_ADDRESS <= 4'hC |-> AVS_RESPONSE == 2'h0)
        else $error("mapped access refused");
    a_route_onehot: assert property (
        $onehot0({ROUTE_EXT, ROUTE_VREF, ROUTE_TEMP, ROUTE_FVR}) && ROUTE_EXT[9:3] == 7'h0)
        else $error("more than one or a reserved route");
    a_off_quiet: assert property (!CORE_POWER && !$past(CORE_POWER) |->
        {ROUTE_EXT, ROUTE_VREF, ROUTE_TEMP, ROUTE_FVR, CORE_START} == 21'h0)
        else $error("activity while converter off");
    a_start_power: assert property (CORE_START |-> CORE_POWER)
        else $error("start without power");
    a_start_pulse: assert property (CORE_START |=> !CORE_START)
        else $error("start longer than one cycle");
    a_stop_pulse: assert property (CORE_STOP |-> !CORE_START ##1 !CORE_STOP)
        else $error("bad stop pulse");
endmodule
bind acc_top acc_top_assertions i_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .AVS_RESPONSE(AVS_RESPONSE), .CORE_START(CORE_START), .CORE_STOP(CORE_STOP),
    .CORE_POWER(CORE_POWER), .ROUTE_EXT(ROUTE_EXT), .ROUTE_VREF(ROUTE_VREF),
    .ROUTE_TEMP(ROUTE_TEMP), .ROUTE_FVR(ROUTE_FVR));

// ==== acc_core_model.sv ====
// behavioural conversion core with a set conversion time
`timescale 1ns/10ps
module acc_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic stop,
    input wire logic [9:0] res_value,
    input wire logic [7:0] delay,
    output logic done,
    output logic [9:0] result
);
    logic busy_reg;
    logic [7:0] cnt_reg;
    logic [9:0] tick_reg;
    // result word is only valid with done, otherwise it keeps moving
    assign result = done ? res_value : tick_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            cnt_reg <= 8'h00;
            done <= 1'b0;
            tick_reg <= 10'h000;
        end else begin
            done <= 1'b0;
            tick_reg <= tick_reg + 10'h001;
            if (start) begin
                busy_reg <= 1'b1;
                cnt_reg <= delay;
            end else if (stop) begin
                busy_reg <= 1'b0;
            end else if (busy_reg && cnt_reg == 8'h00) begin
                busy_reg <= 1'b0;
                done <= 1'b1;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule

// ==== adc_channel_conversion_control_test.sv ====
// self-checking bench for the conversion control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module adc_channel_conversion_control_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [1:0] resp;
    logic [16:0] ext;
    logic wait_r, c_start, c_stop, c_pow, c_irq, irq, vref, temp, fvr, c_done;
    logic [9:0] c_res;
    logic [9:0] res_val = 10'h000;
    logic [7:0] dly = 8'h04;
    logic [7:0] q;
    logic [1:0] qr;
    logic [4:0] code;
    logic [4:0] tbl [13] = '{5'h00, 5'h01, 5'h02, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E,
        5'h0F, 5'h10, 5'h1B, 5'h1D, 5'h1F};
    int miscompares = 0, cmp_count = 0, cyc = 0, starts = 0, stops = 0, st0, sp0;
    int seed = 32'hda1a;
    always #4 clk = ~clk;
    always @(negedge clk) begin
        cyc++;
        starts += int'(c_start === 1'b1);
        stops += int'(c_stop === 1'b1);
        if (cyc == 30000) begin
            miscompares++;
            test_done;
        end
    end
    acc_top #(.INSTR_DIV(4)) i_dut (.CLK_SYS(clk), .RST(rst), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r), .AVS_RESPONSE(resp),
        .CORE_DONE(c_done), .CORE_RESULT(c_res), .CORE_START(c_start), .CORE_STOP(c_stop),
        .CORE_POWER(c_pow), .ROUTE_EXT(ext), .ROUTE_VREF(vref), .ROUTE_TEMP(temp),
        .ROUTE_FVR(fvr), .CONV_IRQ(c_irq), .IRQ(irq));
    acc_core_model i_core (.clk(clk), .rst(rst), .start(c_start), .stop(c_stop),
        .res_value(res_val), .delay(dly), .done(c_done), .result(c_res));
    function automatic logic [19:0] exp_route(input logic [4:0] c);
        exp_route = 20'h0;
        if (c <= 5'h02 || (c >= 5'h0A && c <= 5'h10)) exp_route[c + 3] = 1'b1;
        if (c == 5'h1B) exp_route[2] = 1'b1;
        if (c == 5'h1D) exp_route[1] = 1'b1;
        if (c == 5'h1F) exp_route[0] = 1'b1;
    endfunction
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 100);
        q = rdat[7:0];
        qr = resp;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m,
        input string nm);
        bus(1'b0, a, 8'h00);
        `CHK(nm, e & m, q & m)
    endtask
    task automatic settle;
        repeat (2) @(negedge clk);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (c_done !== 1'b1 && n < 300);
        repeat (2) @(posedge clk);
    endtask
    task automatic conv(input logic [7:0] com, input logic [7:0] ctl, input logic [7:0] d);
        res_val <= 10'($random(seed));
        dly <= d;
        st0 = starts;
        bus(1'b1, 4'h6, com);
        bus(1'b1, 4'h0, ctl & 8'hFD);
        bus(1'b1, 4'h0, ctl);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rdchk(4'h0, 8'h00, 8'hFF, "ctrl reset");
        rdchk(4'h8, 8'h00, 8'hFF, "enable reset");
        rdchk(4'h6, 8'h00, 8'hFF, "common reset");
        bus(1'b1, 4'h0, 8'hFE);
        rdchk(4'h1, 8'h7C, 8'hFF, "ctrl other bank");
        bus(1'b0, 4'hD, 8'h00);
        `CHK("unmapped", 10'h200, {qr, q})
        for (int i = 0; i < 24; i++) begin
            code = (i < 13) ? tbl[i] : 5'($random(seed));
            bus(1'b1, 4'h0, {1'b0, code, 2'b01});
            settle;
            `CHK("route", exp_route(code), {ext, vref, temp, fvr})
        end
        bus(1'b1, 4'h0, 8'h7C);
        settle;
        `CHK("off routes", 21'h0, {c_pow, ext, vref, temp, fvr})
        bus(1'b1, 4'h8, 8'h44);
        bus(1'b1, 4'hA, 8'h40);
        bus(1'b1, 4'hC, 8'h03);
        rdchk(4'h8, 8'h40, 8'hFF, "enable bit2");
        conv(8'h00, 8'h2B, 8'($random(seed)) & 8'h1F);
        wait_done;
        rdchk(4'h0, 8'h29, 8'hFF, "go cleared");
        rdchk(4'h2, res_val[7:0], 8'hFF, "result low");
        rdchk(4'h5, {6'h0, res_val[9:8]}, 8'hFF, "result high");
        rdchk(4'h9, 8'h40, 8'h40, "conv flag");
        `CHK("irq lines", 2'b11, {c_irq, irq})
        bus(1'b1, 4'h8, 8'h00);
        settle;
        `CHK("irq blocked", 1'b0, c_irq)
        bus(1'b1, 4'h8, 8'h40);
        bus(1'b1, 4'hA, 8'h00);
        settle;
        `CHK("gate off", 1'b0, c_irq)
        bus(1'b1, 4'hA, 8'h40);
        bus(1'b1, 4'hC, 8'h00);
        settle;
        `CHK("masked", 1'b0, irq)
        bus(1'b1, 4'hB, 8'h03);
        bus(1'b1, 4'hC, 8'h03);
        bus(1'b1, 4'h9, 8'h00);
        settle;
        `CHK("cleared", 2'b00, {c_irq, irq})
        for (int k = 0; k < 2; k++) begin
            conv(8'h70, 8'h0B, 8'h3C);
            bus(1'b1, 4'h0, 8'h0B);
            rdchk(4'h0, 8'h0B, 8'hFF, "go held");
            sp0 = stops;
            bus(1'b1, 4'h0, (k == 0) ? 8'h09 : 8'h00);
            settle;
            rdchk(4'h0, (k == 0) ? 8'h09 : 8'h00, 8'hFF, "go stopped");
            `CHK("pulses", {k[0], 16'(st0 + 1), 16'(sp0 + 1)}, {!c_pow, 16'(starts), 16'(stops)})
            rdchk(4'h9, 8'h00, 8'h40, "no flag");
            rdchk(4'hB, 8'h02, 8'h03, "abort status");
            bus(1'b1, 4'hB, 8'h02);
        end
        conv(8'h01, 8'h0B, 8'h14);
        wait_done;
        rdchk(4'h0, 8'h0B, 8'hFF, "go first");
        wait_done;
        rdchk(4'h0, 8'h09, 8'hFF, "go second");
        `CHK("two starts", st0 + 2, starts)
        rdchk(4'h9, 8'h40, 8'h40, "flag double");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(4'h0, 8'h00, 8'hFF, "ctrl after reset");
        rdchk(4'h9, 8'h00, 8'h40, "flag after reset");
        test_done;
    end
endmodule
